// [logic/acmp_top.sv]
// Comparator control and status logic with APB register access
// How it works
// - Result bit reads one when positive input is above negative input.
// - Raw comparator output is synchronised, adding two cycles latency.
// - Edge mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Event flag at bit 4 is set on the selected event.
// - Event flag clears when the interrupt vector is taken.
// - Writing one to the flag clears it; zero leaves it.
// - Interrupt request needs flag, enable bit 3 and global enable.
// - Bit 7 powers the comparator off, writable at any time.
// - Bit 6 selects the bandgap instead of the positive pin.
// - Bit 2 routes the comparator output to the timer capture input.
// - Mux enabled and converter off: codes 0 to 7 pick channel pins.
// - Otherwise the negative pin drives the negative input.
// - Input buffer disable bits 2:1 force matching pin read bits to zero.
// - Converter control B: mux enable bit 6, bits 5 and 3 zero.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "acmp_cfg.svh"

module acmp_top
(
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output var  logic [31:0]          prdata,
	output var  logic                 pready,
	output var  logic                 pslverr,
	input  wire logic                 cmp_raw_i,
	input  wire logic                 converter_enable_i,
	input  wire logic [4:0]           channel_select_code_i,
	input  wire logic                 global_irq_enable_i,
	input  wire logic                 irq_ack_i,
	input  wire logic [7:0]           pin_level_i,
	output var  logic                 irq_o,
	output var  logic                 power_off_o,
	output var  logic                 bandgap_sel_o,
	output var  acmp_pkg::acmp_neg_sel_t neg_sel_o,
	output var  logic                 capture_o,
	output var  logic [7:0]           conv_ctrl_b_o,
	output var  logic [7:0]           input_buffer_off_o
);

	acmp_pkg::acmp_ctrl_t ctrl_q;
	logic                 flag_q;
	logic [7:0]           conv_b_q;
	logic [7:0]           din_off_q;
	logic [7:0]           pin_read_q;
	logic                 result;
	logic                 cmp_event;
	logic                 wr_done;
	logic                 setup;
	logic [7:0]           rd_byte;
	logic                 mapped;

	function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
		hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

	acmp_sync u_sync
	(
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.async_i (cmp_raw_i),
		.sync_o  (result)
	);

	acmp_edge u_edge
	(
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.level_i (result),
		.mode_i  (ctrl_q.edge_mode),
		.event_o (cmp_event)
	);

	assign setup   = psel & ~penable;
	assign wr_done = psel & penable & pready & pwrite;

	always_comb
	begin
		mapped  = 1'b1;
		rd_byte = 8'h00;
		if (hit(paddr, `ACMP_IDX_CTRL_STATUS))
			rd_byte = {ctrl_q.power_off, ctrl_q.bandgap_positive_select, result, flag_q,
				ctrl_q.compare_irq_enable, ctrl_q.capture_route_enable, ctrl_q.edge_mode};
		else if (hit(paddr, `ACMP_IDX_IRQ_MASK))
			rd_byte = {3'h0, ctrl_q.compare_irq_enable, 4'h0};
		else if (hit(paddr, `ACMP_IDX_CONV_B))
			rd_byte = conv_b_q & `ACMP_CONV_B_RW_MASK;
		else if (hit(paddr, `ACMP_IDX_DIN_DISABLE))
			rd_byte = din_off_q;
		else if (hit(paddr, `ACMP_IDX_PIN_READ))
			rd_byte = pin_read_q;
		else
			mapped = 1'b0;
	end

	// Zero wait states: ready rises in the cycle after setup
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			if (setup && !pwrite)
				prdata <= {24'h00_0000, rd_byte};
		end
	end

	// Control fields; software must quiet the interrupt before edits
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			ctrl_q <= `ACMP_RST_CTRL;
		else if (wr_done && hit(paddr, `ACMP_IDX_CTRL_STATUS))
		begin
			ctrl_q.power_off               <= pwdata[`ACMP_BIT_POWER_OFF];
			ctrl_q.bandgap_positive_select <= pwdata[`ACMP_BIT_BANDGAP];
			ctrl_q.compare_irq_enable      <= pwdata[`ACMP_BIT_IRQ_EN];
			ctrl_q.capture_route_enable    <= pwdata[`ACMP_BIT_CAPTURE];
			ctrl_q.edge_mode               <= acmp_pkg::acmp_edge_mode_t'(pwdata[1:0]);
		end
		else if (wr_done && hit(paddr, `ACMP_IDX_IRQ_MASK))
			ctrl_q.compare_irq_enable <= pwdata[`ACMP_BIT_FLAG];
	end

	// Set beats clear so an event coinciding with a clear is kept
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			flag_q <= 1'b0;
		else if (cmp_event)
			flag_q <= 1'b1;
		else if (irq_ack_i)
			flag_q <= 1'b0;
		else if (wr_done && hit(paddr, `ACMP_IDX_CTRL_STATUS) && pwdata[`ACMP_BIT_FLAG])
			flag_q <= 1'b0;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			conv_b_q <= `ACMP_RST_CONV_B;
		else if (wr_done && hit(paddr, `ACMP_IDX_CONV_B))
			conv_b_q <= pwdata[7:0] & `ACMP_CONV_B_RW_MASK;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			din_off_q <= `ACMP_RST_DIN_DISABLE;
		else if (wr_done && hit(paddr, `ACMP_IDX_DIN_DISABLE))
			din_off_q <= pwdata[7:0];
	end

	// Only the two comparator pins have gated digital buffers here
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			pin_read_q <= 8'h00;
		else
		begin
			pin_read_q    <= pin_level_i;
			pin_read_q[1] <= pin_level_i[1] & ~din_off_q[`ACMP_BIT_BUF_OFF_ONE];
			pin_read_q[2] <= pin_level_i[2] & ~din_off_q[`ACMP_BIT_BUF_OFF_TWO];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= flag_q & ctrl_q.compare_irq_enable & global_irq_enable_i;
	end

	// Codes above seven are not defined for the mux; fall back to the pin
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			neg_sel_o <= '0;
		else
		begin
			neg_sel_o.use_channel <= conv_b_q[`ACMP_BIT_MUX_EN] & ~converter_enable_i
				& (channel_select_code_i[4:3] == 2'h0);
			neg_sel_o.channel     <= channel_select_code_i[2:0];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			power_off_o        <= 1'b0;
			bandgap_sel_o      <= 1'b0;
			capture_o          <= 1'b0;
			conv_ctrl_b_o      <= 8'h00;
			input_buffer_off_o <= 8'h00;
		end
		else
		begin
			power_off_o        <= ctrl_q.power_off;
			bandgap_sel_o      <= ctrl_q.bandgap_positive_select;
			capture_o          <= ctrl_q.capture_route_enable & result;
			conv_ctrl_b_o      <= conv_b_q;
			input_buffer_off_o <= din_off_q;
		end
	end

	property p_result_latency;
		@(posedge mclk_i) disable iff (!rst_n_i)
		$past(rst_n_i, 2) |-> result == $past(cmp_raw_i, 2);
	endproperty
	a_result_latency: assert property (p_result_latency)
		else $error("Result does not follow raw input after two cycles");

	property p_rise_sets;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(ctrl_q.edge_mode == acmp_pkg::ACMP_EDGE_RISE) && $rose(result) |=> flag_q;
	endproperty
	a_rise_sets: assert property (p_rise_sets)
		else $error("Rising edge did not set the flag");

	property p_fall_sets;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(ctrl_q.edge_mode == acmp_pkg::ACMP_EDGE_FALL) && $fell(result) |=> flag_q;
	endproperty
	a_fall_sets: assert property (p_fall_sets)
		else $error("Falling edge did not set the flag");

	property p_toggle_sets;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(ctrl_q.edge_mode == acmp_pkg::ACMP_EDGE_TOGGLE) && $changed(result) |=> flag_q;
	endproperty
	a_toggle_sets: assert property (p_toggle_sets)
		else $error("Toggle did not set the flag");

	property p_ready_after_setup;
		@(posedge mclk_i) disable iff (!rst_n_i)
		pready |-> $past(setup);
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("Ready without a preceding setup cycle");

	property p_reserved_quiet;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(ctrl_q.edge_mode == acmp_pkg::ACMP_EDGE_RESERVED) && !flag_q |=> !flag_q;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet)
		else $error("Reserved mode set the flag");

	property p_event_sets;
		@(posedge mclk_i) disable iff (!rst_n_i)
		cmp_event |=> flag_q;
	endproperty
	a_event_sets: assert property (p_event_sets)
		else $error("Event lost");

	property p_ack_clears;
		@(posedge mclk_i) disable iff (!rst_n_i)
		irq_ack_i && !cmp_event |=> !flag_q;
	endproperty
	a_ack_clears: assert property (p_ack_clears)
		else $error("Vector acknowledge did not clear flag");

	property p_w1c;
		@(posedge mclk_i) disable iff (!rst_n_i)
		wr_done && hit(paddr, `ACMP_IDX_CTRL_STATUS) && !cmp_event
			|=> flag_q == ($past(flag_q) && !$past(pwdata[4]) && !$past(irq_ack_i));
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("Flag write-one-to-clear wrong");

	property p_irq;
		@(posedge mclk_i) disable iff (!rst_n_i)
		flag_q && ctrl_q.compare_irq_enable && global_irq_enable_i |=> irq_o;
	endproperty
	a_irq: assert property (p_irq)
		else $error("Interrupt not raised");

	property p_irq_gated;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!global_irq_enable_i || !ctrl_q.compare_irq_enable |=> !irq_o;
	endproperty
	a_irq_gated: assert property (p_irq_gated)
		else $error("Interrupt raised while disabled");

	property p_power_write;
		@(posedge mclk_i) disable iff (!rst_n_i)
		wr_done && hit(paddr, `ACMP_IDX_CTRL_STATUS) |=> ##1 power_off_o == $past(pwdata[7], 2)
			&& bandgap_sel_o == $past(pwdata[6], 2);
	endproperty
	a_power_write: assert property (p_power_write)
		else $error("Power or bandgap select not applied");

	property p_capture;
		@(posedge mclk_i) disable iff (!rst_n_i)
		capture_o |-> $past(ctrl_q.capture_route_enable) && $past(result);
	endproperty
	a_capture: assert property (p_capture)
		else $error("Capture driven without routing");

	property p_neg_mux;
		@(posedge mclk_i) disable iff (!rst_n_i)
		converter_enable_i || !conv_b_q[6] |=> !neg_sel_o.use_channel;
	endproperty
	a_neg_mux: assert property (p_neg_mux)
		else $error("Channel used while mux must be off");

	property p_neg_channel;
		@(posedge mclk_i) disable iff (!rst_n_i)
		conv_b_q[6] && !converter_enable_i && channel_select_code_i == 5'h05
			|=> neg_sel_o.use_channel && neg_sel_o.channel == 3'h5;
	endproperty
	a_neg_channel: assert property (p_neg_channel)
		else $error("Channel five not routed");

	property p_pin_gate;
		@(posedge mclk_i) disable iff (!rst_n_i)
		din_off_q[1] |=> !pin_read_q[1];
	endproperty
	a_pin_gate: assert property (p_pin_gate)
		else $error("Disabled pin buffer read nonzero");

	property p_conv_b_zero;
		@(posedge mclk_i) disable iff (!rst_n_i)
		setup && !pwrite && hit(paddr, `ACMP_IDX_CONV_B) |=> prdata[5] == 1'b0 && prdata[3] == 1'b0;
	endproperty
	a_conv_b_zero: assert property (p_conv_b_zero)
		else $error("Read-only bits of control B not zero");

endmodule

`default_nettype wire

// [logic/acmp_cfg.svh]
// Register indices, field positions and reset values of the comparator control block
`ifndef ACMP_CFG_SVH
`define ACMP_CFG_SVH

`define ACMP_IDX_DIN_DISABLE   6'h01
`define ACMP_IDX_PIN_READ      6'h02
`define ACMP_IDX_CONV_B        6'h03
`define ACMP_IDX_CTRL_STATUS   6'h08
`define ACMP_IDX_IRQ_MASK      6'h09

`define ACMP_BIT_POWER_OFF     3'd7
`define ACMP_BIT_BANDGAP       3'd6
`define ACMP_BIT_RESULT        3'd5
`define ACMP_BIT_FLAG          3'd4
`define ACMP_BIT_IRQ_EN        3'd3
`define ACMP_BIT_CAPTURE       3'd2
`define ACMP_BIT_MUX_EN        3'd6
`define ACMP_BIT_BUF_OFF_ONE   3'd1
`define ACMP_BIT_BUF_OFF_TWO   3'd2

`define ACMP_CONV_B_RW_MASK    8'hD7
`define ACMP_RST_CTRL          6'h00
`define ACMP_RST_CONV_B        8'h00
`define ACMP_RST_DIN_DISABLE   8'h00

`endif

// [logic/acmp_pkg.sv]
// Types shared by the comparator control modules
package acmp_pkg;

	typedef enum logic [1:0]
	{
		ACMP_EDGE_TOGGLE   = 2'h0,
		ACMP_EDGE_RESERVED = 2'h1,
		ACMP_EDGE_FALL     = 2'h2,
		ACMP_EDGE_RISE     = 2'h3
	} acmp_edge_mode_t;

	typedef struct packed
	{
		logic            power_off;
		logic            bandgap_positive_select;
		logic            compare_irq_enable;
		logic            capture_route_enable;
		acmp_edge_mode_t edge_mode;
	} acmp_ctrl_t;

	typedef struct packed
	{
		logic       use_channel;
		logic [2:0] channel;
	} acmp_neg_sel_t;

endpackage

// [logic/acmp_sync.sv]
// Two-stage synchroniser for the raw comparator output
`timescale 1ns/10ps
`default_nettype none

module acmp_sync
(
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic async_i,
	output var  logic sync_o
);

	logic meta_q;

	// First stage feeds only the second
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= 1'b0;
			sync_o <= 1'b0;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule

`default_nettype wire

// [logic/acmp_edge.sv]
// Edge detector choosing the comparator event by mode
`timescale 1ns/10ps
`default_nettype none

module acmp_edge
(
	input  wire logic                     mclk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     level_i,
	input  wire acmp_pkg::acmp_edge_mode_t mode_i,
	output logic                          event_o
);

	logic prev_q;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			prev_q <= 1'b0;
		else
			prev_q <= level_i;
	end

	always_comb
	begin
		unique case (mode_i)
			acmp_pkg::ACMP_EDGE_TOGGLE:   event_o = level_i ^ prev_q;
			acmp_pkg::ACMP_EDGE_RESERVED: event_o = 1'b0;
			acmp_pkg::ACMP_EDGE_FALL:     event_o = prev_q & ~level_i;
			acmp_pkg::ACMP_EDGE_RISE:     event_o = level_i & ~prev_q;
		endcase
	end

endmodule

`default_nettype wire

// [test/acmp_analog_model.sv]
// Behavioural analog side: input pins, bandgap and channel pins feeding the comparator
`timescale 1ns/10ps
`default_nettype none

module acmp_analog_model
#(
	parameter int BANDGAP_LEVEL = 450
)
(
	input  wire logic                    bandgap_sel_i,
	input  wire acmp_pkg::acmp_neg_sel_t neg_sel_i,
	input  wire logic                    power_off_i,
	input  wire logic [9:0]              pos_pin_i,
	input  wire logic [9:0]              neg_pin_i,
	input  wire logic [79:0]             chan_i,
	output var  logic                    cmp_raw_o
);
	int pos_v;
	int neg_v;

	// Unpowered output is held low; a real one would be undefined
	always_comb
	begin
		pos_v = bandgap_sel_i ? BANDGAP_LEVEL : int'(pos_pin_i);
		neg_v = neg_sel_i.use_channel ? int'(chan_i[neg_sel_i.channel*10 +: 10]) : int'(neg_pin_i);
		cmp_raw_o = !power_off_i && (pos_v > neg_v);
	end
endmodule
`default_nettype wire

// [test/tb_analog_comparator_control.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
`default_nettype none

module tb_analog_comparator_control;
	logic                    mclk_i = 1'b0;
	logic                    rst_n_i = 1'b0;
	logic                    psel = 1'b0;
	logic                    penable = 1'b0;
	logic                    pwrite = 1'b0;
	logic [7:0]              paddr = 8'h00;
	logic [31:0]             pwdata = 32'h0;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	logic                    cmp_raw;
	logic                    conv_en = 1'b0;
	logic                    global_en = 1'b0;
	logic                    irq_ack = 1'b0;
	logic [4:0]              chan_code = 5'h00;
	logic [7:0]              pin_level = 8'h00;
	logic [7:0]              conv_b_out;
	logic [7:0]              buf_off_out;
	logic                    irq;
	logic                    power_off;
	logic                    bandgap_sel;
	logic                    capture;
	acmp_pkg::acmp_neg_sel_t neg_sel;
	logic [9:0]              pos_pin = 10'h064;
	logic [9:0]              neg_pin = 10'h12C;
	logic [79:0]             chan = {8{10'h3FF}};
	logic [31:0]             rd;
	logic                    err;
	logic [7:0]              din_m;
	logic [7:0]              pin_m;
	logic                    fl;
	int                      err_count = 0;
	int                      checks_done = 0;
	int                      seed = 9390;
	int                      cycles = 0;

	acmp_top DUT
	(
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp_raw_i(cmp_raw), .converter_enable_i(conv_en), .channel_select_code_i(chan_code),
		.global_irq_enable_i(global_en), .irq_ack_i(irq_ack), .pin_level_i(pin_level),
		.irq_o(irq), .power_off_o(power_off), .bandgap_sel_o(bandgap_sel), .neg_sel_o(neg_sel),
		.capture_o(capture), .conv_ctrl_b_o(conv_b_out), .input_buffer_off_o(buf_off_out)
	);

	acmp_analog_model analog
	(
		.bandgap_sel_i(bandgap_sel), .neg_sel_i(neg_sel), .power_off_i(power_off),
		.pos_pin_i(pos_pin), .neg_pin_i(neg_pin), .chan_i(chan), .cmp_raw_o(cmp_raw)
	);

	initial
	begin
		forever #2 mclk_i = ~mclk_i;
	end

	task complete_run;
		$display("Comparisons %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge mclk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			err_count++;
			complete_run;
		end
	end

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge mclk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk_i);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check("wait_states", 32'h1, 32'(n));
	endtask

	task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask

	task idle(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	initial
	begin
		idle(12);
		rst_n_i <= 1'b1;
		idle(1);
		rd_chk("ctrl_reset", 8'h20, 32'h0);
		rd_chk("conv_b_reset", 8'h0C, 32'h0);
		rd_chk("din_reset", 8'h04, 32'h0);
		apb(1'b1, 8'h0C, 32'hFF);
		rd_chk("conv_b", 8'h0C, 32'hD7);
		check("conv_b_out", 32'hD7, {24'h0, conv_b_out});
		apb(1'b1, 8'h40, 32'hFF);
		check("slverr_wr", 32'h1, {31'h0, err});
		rd_chk("unmapped", 8'h40, 32'h0);
		check("slverr_rd", 32'h1, {31'h0, err});
		repeat (4)
		begin
			pin_level <= 8'($random(seed));
			din_m = 8'($random(seed));
			apb(1'b1, 8'h04, {24'h0, din_m});
			pin_m = pin_level & ~(din_m & 8'h06);
			rd_chk("pin_read", 8'h08, {24'h0, pin_m});
			check("buf_off", {24'h0, din_m}, {24'h0, buf_off_out});
		end
		for (int e = 0; e < 3; e++)
		begin
			apb(1'b1, 8'h0C, (e != 0) ? 32'h40 : 32'h0);
			conv_en <= (e == 1);
			for (int c = 0; c < 32; c++)
			begin
				chan_code <= 5'(c);
				idle(3);
				fl = (e == 2) && (c < 8);
				check("neg_use", {31'h0, fl}, {31'h0, neg_sel.use_channel});
				if (fl)
					check("neg_chan", 32'(c & 7), {29'h0, neg_sel.channel});
			end
		end
		apb(1'b1, 8'h0C, 32'h0);
		conv_en <= 1'b0;
		apb(1'b1, 8'h20, 32'h54);
		idle(5);
		check("bandgap_sel", 32'h1, {31'h0, bandgap_sel});
		check("capture_on", 32'h1, {31'h0, capture});
		rd_chk("ctrl_bg", 8'h20, 32'h74);
		apb(1'b1, 8'h20, 32'h90);
		idle(5);
		check("power_off", 32'h1, {31'h0, power_off});
		check("capture_off", 32'h0, {31'h0, capture});
		rd_chk("ctrl_pwr", 8'h20, 32'h90);
		apb(1'b1, 8'h20, 32'h10);
		rd_chk("ctrl_clr", 8'h20, 32'h0);
		apb(1'b1, 8'h20, 32'h04);
		idle(2);
		pos_pin <= 10'h3FF;
		idle(3);
		check("capture_early", 32'h0, {31'h0, capture});
		idle(1);
		check("capture_late", 32'h1, {31'h0, capture});
		pos_pin <= 10'h064;
		idle(6);
		for (int m = 0; m < 4; m++)
		begin
			// Mode is only changed with the interrupt enable clear
			apb(1'b1, 8'h20, 32'h10 | m);
			rd_chk("ctrl_mode", 8'h20, 32'(m));
			pos_pin <= 10'h3FF;
			idle(6);
			fl = (m == 0 || m == 3);
			rd_chk("ctrl_rise", 8'h20, 32'h20 | (32'(fl) << 4) | m);
			apb(1'b1, 8'h20, 32'(m));
			rd_chk("ctrl_keep", 8'h20, 32'h20 | (32'(fl) << 4) | m);
			apb(1'b1, 8'h20, 32'h10 | m);
			pos_pin <= 10'h064;
			idle(6);
			fl = (m == 0 || m == 2);
			rd_chk("ctrl_fall", 8'h20, (32'(fl) << 4) | m);
		end
		global_en <= 1'b1;
		apb(1'b1, 8'h20, 32'h1B);
		pos_pin <= 10'h3FF;
		idle(7);
		check("irq_set", 32'h1, {31'h0, irq});
		global_en <= 1'b0;
		idle(3);
		check("irq_global", 32'h0, {31'h0, irq});
		apb(1'b1, 8'h24, 32'h0);
		global_en <= 1'b1;
		idle(3);
		check("irq_masked", 32'h0, {31'h0, irq});
		apb(1'b1, 8'h24, 32'h10);
		idle(3);
		check("irq_unmasked", 32'h1, {31'h0, irq});
		irq_ack <= 1'b1;
		idle(1);
		irq_ack <= 1'b0;
		idle(4);
		check("irq_ack", 32'h0, {31'h0, irq});
		rd_chk("ctrl_ack", 8'h20, 32'h2B);
		complete_run;
	end
endmodule
`default_nettype wire
